// file: scrsel_pkg.sv
package scrsel_pkg;

    // ------------------------------------------------------------
    // Configured scrambler modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCRSEL_MODE_AUTO     = 3'h0,
        SCRSEL_MODE_STD308   = 3'h1,
        SCRSEL_MODE_STD309   = 3'h2,
        SCRSEL_MODE_V35      = 3'h3,
        SCRSEL_MODE_SAT      = 3'h4,
        SCRSEL_MODE_ALT_V35  = 3'h5,
        SCRSEL_MODE_ALT_SAT  = 3'h6,
        SCRSEL_MODE_OFF      = 3'h7
    } scrsel_mode_t;

    // ------------------------------------------------------------
    // Scrambler actually applied
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCRSEL_SCR_NONE      = 3'h0,
        SCRSEL_SCR_SAT_SELF  = 3'h1,
        SCRSEL_SCR_V35_SELF  = 3'h2,
        SCRSEL_SCR_MUX_SYNC  = 3'h3,
        SCRSEL_SCR_RS_SYNC   = 3'h4,
        SCRSEL_SCR_TURBO     = 3'h5
    } scrsel_scr_t;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] SCRSEL_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] SCRSEL_ADDR_STATUS = 4'h1;
    localparam logic [3:0] SCRSEL_ADDR_DIV    = 4'h2;
    localparam logic [3:0] SCRSEL_ADDR_VER    = 4'h3;

    localparam int SCRSEL_CTRL_TXMODE_LSB = 0;
    localparam int SCRSEL_CTRL_RXMODE_LSB = 4;
    localparam int SCRSEL_CTRL_TURBO_BIT  = 8;
    localparam int SCRSEL_CTRL_MUX_BIT    = 9;
    localparam int SCRSEL_CTRL_RS_BIT     = 10;
    localparam int SCRSEL_CTRL_PREF_BIT   = 11;
    localparam int SCRSEL_CTRL_W          = 12;

    localparam int SCRSEL_STAT_TXSCR_LSB  = 0;
    localparam int SCRSEL_STAT_TXINV_BIT  = 3;
    localparam int SCRSEL_STAT_RXSCR_LSB  = 4;
    localparam int SCRSEL_STAT_RXINV_BIT  = 7;
    localparam int SCRSEL_STAT_TXBUF_BIT  = 8;
    localparam int SCRSEL_STAT_RXBUF_BIT  = 9;

    localparam logic [SCRSEL_CTRL_W-1:0] SCRSEL_CTRL_RST = 12'h000;
    // Arbitrary neutral block version value
    localparam logic [31:0] SCRSEL_VERSION = 32'h0000_0100;

    localparam int SCRSEL_DATA_W = 8;
    localparam int SCRSEL_BUF_DEPTH = 2;

endpackage : scrsel_pkg

// file: scrsel_pick.sv
`timescale 1ns/1ps
module scrsel_pick
    import scrsel_pkg::*;
(
    input  wire scrsel_mode_t mode,     // Configured mode
    input  wire logic         turbo_en, // Block turbo FEC enabled
    input  wire logic         mux_en,   // Framing multiplexer enabled
    input  wire logic         rs_en,    // Reed-Solomon enabled
    input  wire logic         pref_309, // Auto prefers 309 behaviour
    output scrsel_scr_t       scr,      // Chosen scrambler
    output logic              invert    // Data inversion
);

    function automatic scrsel_scr_t std_pick(input logic is309, input logic m,
                                             input logic r);
        if (m) begin
            std_pick = SCRSEL_SCR_MUX_SYNC;
        end else if (r && !is309) begin
            std_pick = SCRSEL_SCR_RS_SYNC;
        end else begin
            std_pick = SCRSEL_SCR_SAT_SELF;
        end
    endfunction : std_pick

    always_comb begin
        invert = 1'b0;
        case (mode)
            SCRSEL_MODE_AUTO: begin
                if (!turbo_en) begin
                    scr = std_pick(pref_309, mux_en, rs_en);
                end else if (!mux_en) begin
                    scr = SCRSEL_SCR_TURBO;
                end else begin
                    scr = std_pick(1'b0, mux_en, rs_en);
                end
            end
            SCRSEL_MODE_STD308: scr = std_pick(1'b0, mux_en, rs_en);
            SCRSEL_MODE_STD309: scr = std_pick(1'b1, mux_en, rs_en);
            SCRSEL_MODE_V35:    scr = SCRSEL_SCR_V35_SELF;
            SCRSEL_MODE_SAT:    scr = SCRSEL_SCR_SAT_SELF;
            SCRSEL_MODE_ALT_V35: begin
                scr    = SCRSEL_SCR_V35_SELF;
                invert = 1'b1;
            end
            SCRSEL_MODE_ALT_SAT: begin
                scr    = SCRSEL_SCR_SAT_SELF;
                invert = 1'b1;
            end
            default: scr = SCRSEL_SCR_NONE;
        endcase
    end

endmodule : scrsel_pick

// file: scrsel_buf.sv
`timescale 1ns/1ps
module scrsel_buf
    import scrsel_pkg::*;
(
    input  wire logic                     core_clk, // Clock
    input  wire logic                     rst,      // Async reset
    input  wire logic                     ce,       // Clock enable
    input  wire logic                     in_valid, // Word offered
    output logic                          in_ready, // Room for word
    input  wire logic [SCRSEL_DATA_W-1:0] in_data,  // Word in
    output logic                          out_valid,// Word available
    input  wire logic                     out_ready,// Drain accepts
    output logic [SCRSEL_DATA_W-1:0]      out_data  // Word out
);

    typedef struct packed {
        logic [SCRSEL_BUF_DEPTH-1:0][SCRSEL_DATA_W-1:0] mem;
        logic                                           wp;
        logic                                           rp;
        logic [1:0]                                     cnt;
    } scrsel_buf_st_t;

    scrsel_buf_st_t s_q;
    scrsel_buf_st_t s_d;
    logic           push;
    logic           pop;

    assign in_ready  = (s_q.cnt != 2'h2);
    assign out_valid = (s_q.cnt != 2'h0);
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = ~s_q.wp;
        end
        if (pop) begin
            s_d.rp = ~s_q.rp;
        end
        case ({push, pop})
            2'b10:   s_d.cnt = s_q.cnt + 2'h1;
            2'b01:   s_d.cnt = s_q.cnt - 2'h1;
            default: s_d.cnt = s_q.cnt;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

endmodule : scrsel_buf

// file: scrsel_top.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Auto without turbo FEC: preferred 308/309 choice
// - Auto, turbo without multiplexer: turbo sync scrambler
// - Auto, turbo plus multiplexer: 308 selection
// - Transmit and receive modes held separately
// - 308 plain: self-synchronizing satellite scrambler
// - 308 multiplexer only: multiplexer sync scrambler
// - 308 Reed-Solomon only: Reed-Solomon sync scrambler
// - 308 both enabled: multiplexer sync scrambler
// - 309 as 308, RS-only uses self-sync
// - Fixed modes always use their self-sync scrambler
// - Alternate modes also invert the data
module scrsel_top
    import scrsel_pkg::*;
(
    input  wire logic                     core_clk,    // 200 MHz clock
    input  wire logic                     rst,         // Async reset, high
    input  wire logic                     ce,          // Clock enable
    input  wire logic [3:0]               reg_addr,    // Register address
    input  wire logic [31:0]              reg_wdata,   // Write data
    input  wire logic                     reg_wr,      // Write strobe
    input  wire logic                     reg_rd,      // Read strobe
    output logic [31:0]                   reg_rdata,   // Read data
    input  wire logic                     tx_in_valid, // Tx word from data side
    output logic                          tx_in_ready, // Tx room
    input  wire logic [SCRSEL_DATA_W-1:0] tx_in_data,  // Tx word
    output logic                          tx_out_valid,// Tx word to encoder
    input  wire logic                     tx_out_ready,// Encoder accepts
    output logic [SCRSEL_DATA_W-1:0]      tx_out_data, // Tx word out
    output logic [2:0]                    tx_scr_sel,  // Tx scrambler choice
    input  wire logic                     rx_in_valid, // Rx word from decoder
    output logic                          rx_in_ready, // Rx room
    input  wire logic [SCRSEL_DATA_W-1:0] rx_in_data,  // Rx word
    output logic                          rx_out_valid,// Rx word to data side
    input  wire logic                     rx_out_ready,// Data side accepts
    output logic [SCRSEL_DATA_W-1:0]      rx_out_data, // Rx word out
    output logic [2:0]                    rx_descr_sel // Rx descrambler choice
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SCRSEL_CTRL_W-1:0] ctrl;
        logic [31:0]              rdata;
        scrsel_scr_t              tx_scr;
        logic                     tx_inv;
        scrsel_scr_t              rx_scr;
        logic                     rx_inv;
        logic [15:0]              div;
    } scrsel_st_t;

    scrsel_st_t       s_q;
    scrsel_st_t       s_d;
    scrsel_scr_t      tx_scr_c;
    scrsel_scr_t      rx_scr_c;
    logic             tx_inv_c;
    logic             rx_inv_c;
    scrsel_mode_t     tx_mode;
    scrsel_mode_t     rx_mode;
    logic             turbo_en;
    logic             mux_en;
    logic             rs_en;
    logic             pref_309;
    logic [SCRSEL_DATA_W-1:0] tx_buf_data;
    logic [SCRSEL_DATA_W-1:0] rx_buf_data;

    assign tx_mode  = scrsel_mode_t'(s_q.ctrl[SCRSEL_CTRL_TXMODE_LSB +: 3]);
    assign rx_mode  = scrsel_mode_t'(s_q.ctrl[SCRSEL_CTRL_RXMODE_LSB +: 3]);
    assign turbo_en = s_q.ctrl[SCRSEL_CTRL_TURBO_BIT];
    assign mux_en   = s_q.ctrl[SCRSEL_CTRL_MUX_BIT];
    assign rs_en    = s_q.ctrl[SCRSEL_CTRL_RS_BIT];
    assign pref_309 = s_q.ctrl[SCRSEL_CTRL_PREF_BIT];

    // ------------------------------------------------------------
    // Per-direction selection
    // ------------------------------------------------------------
    scrsel_pick u_tx_pick (
        .mode     (tx_mode),
        .turbo_en (turbo_en),
        .mux_en   (mux_en),
        .rs_en    (rs_en),
        .pref_309 (pref_309),
        .scr      (tx_scr_c),
        .invert   (tx_inv_c)
    );

    scrsel_pick u_rx_pick (
        .mode     (rx_mode),
        .turbo_en (turbo_en),
        .mux_en   (mux_en),
        .rs_en    (rs_en),
        .pref_309 (pref_309),
        .scr      (rx_scr_c),
        .invert   (rx_inv_c)
    );

    // ------------------------------------------------------------
    // Data paths with stall-safe buffers
    // ------------------------------------------------------------
    scrsel_buf u_tx_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (tx_in_valid),
        .in_ready  (tx_in_ready),
        .in_data   (tx_in_data),
        .out_valid (tx_out_valid),
        .out_ready (tx_out_ready),
        .out_data  (tx_buf_data)
    );

    scrsel_buf u_rx_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (rx_in_valid),
        .in_ready  (rx_in_ready),
        .in_data   (rx_in_data),
        .out_valid (rx_out_valid),
        .out_ready (rx_out_ready),
        .out_data  (rx_buf_data)
    );

    // Inversion applied at buffer output, from registered flag
    assign tx_out_data  = s_q.tx_inv ? ~tx_buf_data : tx_buf_data;
    assign rx_out_data  = s_q.rx_inv ? ~rx_buf_data : rx_buf_data;
    assign tx_scr_sel   = s_q.tx_scr;
    assign rx_descr_sel = s_q.rx_scr;
    assign reg_rdata    = s_q.rdata;

    // ------------------------------------------------------------
    // Register access and selection update
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Selection follows config continuously, one cycle behind
        s_d.tx_scr = tx_scr_c;
        s_d.tx_inv = tx_inv_c;
        s_d.rx_scr = rx_scr_c;
        s_d.rx_inv = rx_inv_c;
        s_d.rdata  = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                SCRSEL_ADDR_CTRL: s_d.ctrl = reg_wdata[SCRSEL_CTRL_W-1:0];
                SCRSEL_ADDR_DIV:  s_d.div  = reg_wdata[15:0];
                default:          s_d.ctrl = s_q.ctrl;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                SCRSEL_ADDR_CTRL: s_d.rdata = {20'h00000, s_q.ctrl};
                SCRSEL_ADDR_STATUS: begin
                    s_d.rdata[SCRSEL_STAT_TXSCR_LSB +: 3] = s_q.tx_scr;
                    s_d.rdata[SCRSEL_STAT_TXINV_BIT]      = s_q.tx_inv;
                    s_d.rdata[SCRSEL_STAT_RXSCR_LSB +: 3] = s_q.rx_scr;
                    s_d.rdata[SCRSEL_STAT_RXINV_BIT]      = s_q.rx_inv;
                    s_d.rdata[SCRSEL_STAT_TXBUF_BIT]      = tx_out_valid;
                    s_d.rdata[SCRSEL_STAT_RXBUF_BIT]      = rx_out_valid;
                end
                SCRSEL_ADDR_DIV:  s_d.rdata = {16'h0000, s_q.div};
                SCRSEL_ADDR_VER:  s_d.rdata = SCRSEL_VERSION;
                default:          s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q      <= '0;
            s_q.ctrl <= SCRSEL_CTRL_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

endmodule : scrsel_top

// file: scrsel_sva.sv
`timescale 1ns/1ps
module scrsel_sva
    import scrsel_pkg::*;
(
    input wire logic        core_clk,    // Clock
    input wire logic        rst,         // Reset
    input wire logic        ce,          // Enable
    input wire logic [3:0]  reg_addr,    // Address
    input wire logic [31:0] reg_wdata,   // Write data
    input wire logic        reg_wr,      // Write
    input wire logic [2:0]  tx_scr_sel,  // Tx choice
    input wire logic [2:0]  rx_descr_sel // Rx choice
);
    logic        cw;
    logic        cw_q;
    logic        cw_qq;
    logic        ok;
    logic [11:0] w_q;
    assign cw = reg_wr && ce && reg_addr == 4'h0;
    assign ok = cw_qq && !cw_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cw_q  <= 1'b0;
            cw_qq <= 1'b0;
            w_q   <= 12'h000;
        end else begin
            cw_q  <= cw;
            cw_qq <= cw_q;
            if (cw) begin
                w_q <= reg_wdata[11:0];
            end
        end
    end
    function automatic logic [2:0] tbl(input logic m, input logic r, input logic p);
        tbl = m ? 3'h3 : (r && !p) ? 3'h4 : 3'h1;
    endfunction : tbl
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_auto_plain;
        ok && w_q[2:0] == 3'h0 && !w_q[8] |-> tx_scr_sel == tbl(w_q[9], w_q[10], w_q[11]);
    endproperty
    a_auto_plain: assert property (p_auto_plain) else $error("auto plain choice wrong");
    property p_auto_turbo;
        ok && w_q[2:0] == 3'h0 && w_q[8] && !w_q[9] |-> tx_scr_sel == 3'h5;
    endproperty
    a_auto_turbo: assert property (p_auto_turbo) else $error("auto turbo choice wrong");
    property p_auto_mux;
        ok && w_q[2:0] == 3'h0 && w_q[8] && w_q[9] |-> tx_scr_sel == 3'h3;
    endproperty
    a_auto_mux: assert property (p_auto_mux) else $error("auto mux choice wrong");
    property p_rx_own;
        ok && w_q[6:4] == 3'h3 |-> rx_descr_sel == 3'h2;
    endproperty
    a_rx_own: assert property (p_rx_own) else $error("rx mode not independent");
    property p_m308_mux;
        ok && w_q[2:0] == 3'h1 && w_q[9] |-> tx_scr_sel == 3'h3;
    endproperty
    a_m308_mux: assert property (p_m308_mux) else $error("308 mux choice wrong");
    property p_m308_rs;
        ok && w_q[2:0] == 3'h1 && !w_q[9] |-> tx_scr_sel == (w_q[10] ? 3'h4 : 3'h1);
    endproperty
    a_m308_rs: assert property (p_m308_rs) else $error("308 rs choice wrong");
    property p_m309_rs;
        ok && w_q[2:0] == 3'h2 && !w_q[9] |-> tx_scr_sel == 3'h1;
    endproperty
    a_m309_rs: assert property (p_m309_rs) else $error("309 rs choice wrong");
    property p_fixed_sat;
        (cw && reg_wdata[2:0] == 3'h4) ##1 !cw |=> tx_scr_sel == 3'h1;
    endproperty
    a_fixed_sat: assert property (p_fixed_sat) else $error("fixed mode choice wrong");
    property p_rx_308;
        ok && w_q[6:4] == 3'h1 |-> rx_descr_sel == tbl(w_q[9], w_q[10], 1'b0);
    endproperty
    a_rx_308: assert property (p_rx_308) else $error("rx 308 choice wrong");
endmodule : scrsel_sva

// file: scrsel_partner.sv
`timescale 1ns/1ps
module scrsel_partner (
    input  wire logic       core_clk,     // Clock
    input  wire logic [1:0] stall,        // 0 go, 1 random, 2 hold
    output logic            tx_out_ready, // Encoder accepts
    output logic            rx_out_ready  // Data side accepts
);
    integer seed = 26;
    initial begin
        tx_out_ready = 1'b1;
        rx_out_ready = 1'b1;
    end
    always @(posedge core_clk) begin
        tx_out_ready <= stall == 2'h0 || (stall == 2'h1 && $random(seed) & 1);
        rx_out_ready <= stall == 2'h0 || (stall == 2'h1 && $random(seed) & 1);
    end
endmodule : scrsel_partner

// file: scrsel_top_tb.sv
`timescale 1ns/1ps
module scrsel_top_tb;
    import scrsel_pkg::*;
    logic        core_clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rq[$], tq[$], xq[$];
    logic        tx_in_valid = 1'b0, tx_in_ready, tx_out_valid, tx_out_ready;
    logic        rx_in_valid = 1'b0, rx_in_ready, rx_out_valid, rx_out_ready;
    logic [7:0]  tx_in_data = 8'h00, tx_out_data, rx_in_data = 8'h00, rx_out_data;
    logic [2:0]  tx_scr_sel, rx_descr_sel;
    logic [1:0]  stall = 2'h0;
    logic        rd_q = 1'b0, tinv = 1'b0, rinv = 1'b0;
    integer      num_errors = 0, n_compared = 0, seed = 26, i;
    scrsel_top dut (.core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_out_valid, .tx_out_ready,
        .tx_out_data, .tx_scr_sel, .rx_in_valid, .rx_in_ready, .rx_in_data, .rx_out_valid,
        .rx_out_ready, .rx_out_data, .rx_descr_sel);
    scrsel_partner u_far (.core_clk, .stall, .tx_out_ready, .rx_out_ready);
    always #2.5 core_clk = ~core_clk;
    task automatic report_and_stop;
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [2:0] t(input logic m, input logic r, input logic p);
        t = m ? 3'h3 : (r && !p) ? 3'h4 : 3'h1;
    endfunction : t
    function automatic logic [3:0] es(input logic [2:0] m, input logic [3:0] e);
        case (m)
            3'h0: es = {m == 3'h0 && 1'b0, !e[0] ? t(e[1], e[2], e[3]) : e[1] ? 3'h3 : 3'h5};
            3'h1: es = {1'b0, t(e[1], e[2], 1'b0)};
            3'h2: es = {1'b0, t(e[1], e[2], 1'b1)};
            3'h3: es = 4'h2;
            3'h4: es = 4'h1;
            3'h5: es = 4'hA;
            3'h6: es = 4'h9;
            default: es = 4'h0;
        endcase
    endfunction : es
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
    endtask : rd
    task automatic snd(input logic d, input logic [7:0] w);
        integer k;
        if (d) begin
            rx_in_valid <= 1'b1;
            rx_in_data  <= w;
            xq.push_back({24'h0, w ^ {8{rinv}}});
        end else begin
            tx_in_valid <= 1'b1;
            tx_in_data  <= w;
            tq.push_back({24'h0, w ^ {8{tinv}}});
        end
        for (k = 0; k < 60; k++) begin
            @(posedge core_clk);
            if ((d ? rx_in_ready : tx_in_ready) === 1'b1) break;
        end
        if (d) begin
            rx_in_valid <= 1'b0;
        end else begin
            tx_in_valid <= 1'b0;
        end
        if (k == 60) begin
            num_errors++;
            report_and_stop();
        end
    endtask : snd
    task automatic drain;
        for (i = 0; i < 300 && tq.size() + xq.size() > 0; i++) @(posedge core_clk);
        if (i == 300) begin
            num_errors++;
            report_and_stop();
        end
    endtask : drain
    task automatic flow(input logic [2:0] tm, input logic [2:0] rm);
        wr(4'h0, {25'h0, rm, 1'b0, tm});
        tinv  = es(tm, 4'h0) >> 3;
        rinv  = es(rm, 4'h0) >> 3;
        stall <= 2'h1;
        for (i = 0; i < 12; i++) begin
            snd(1'b0, $random(seed));
            snd(1'b1, $random(seed));
        end
        drain();
    endtask : flow
    // ----------------------------------------------------------------
    // Result monitor
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rd_q) chk(reg_rdata, rq.pop_front());
        rd_q <= reg_rd;
        if (tx_out_valid && tx_out_ready) chk({24'h0, tx_out_data}, tq.pop_front());
        if (rx_out_valid && rx_out_ready) chk({24'h0, rx_out_data}, xq.pop_front());
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h11);
        rd(4'h3, SCRSEL_VERSION);
        rd(4'h9, 32'h0);
        wr(4'h2, 32'h1234ABCD);
        rd(4'h2, 32'hABCD);
        wr(4'h1, 32'hFFF);
        rd(4'h1, 32'h11);
        // Write with clock enable low must not land
        ce <= 1'b0;
        wr(4'h0, 32'h0000_0123);
        ce <= 1'b1;
        rd(4'h0, 32'h0);
        for (int m = 0; m < 8; m++) begin
            for (int e = 0; e < 16; e++) begin
                wr(4'h0, {20'h0, e[3:0], 1'b0, m[2:0] ^ 3'h5, 1'b0, m[2:0]});
                rd(4'h1, {24'h0, es(m[2:0] ^ 3'h5, e[3:0]), es(m[2:0], e[3:0])});
            end
        end
        flow(3'h5, 3'h4);
        flow(3'h4, 3'h6);
        stall <= 2'h2;
        @(posedge core_clk);
        snd(1'b0, 8'h5A);
        @(posedge core_clk);
        snd(1'b0, 8'hC3);
        @(posedge core_clk);
        chk({31'h0, tx_in_ready}, 32'h0);
        rd(4'h1, {22'h0, 1'b0, 1'b1, 4'h9, es(3'h4, 4'h0)});
        stall <= 2'h0;
        drain();
        // Mid-run reset returns to power-up selection
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h11);
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end
endmodule : scrsel_top_tb
bind scrsel_top scrsel_sva u_sva (.core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .tx_scr_sel, .rx_descr_sel);
